// [hw/link_cap_pkg.sv]
package link_cap_pkg;
    // register map
    localparam logic [11:0] LINK_CAP_OFFSET    = 12'h0CC;
    localparam logic [11:0] LOAD_DATA_OFFSET   = 12'h0D4;
    localparam logic [11:0] LOAD_STATUS_OFFSET = 12'h0D8;
    localparam int          ADDR_W             = 12;

    // field positions
    localparam int PORT_IDX_LSB     = 24;
    localparam int RSVD_LSB         = 21;
    localparam int ACT_REP_BIT      = 20;
    localparam int LOSS_REP_BIT     = 19;
    localparam int REFCLK_BIT       = 18;
    localparam int DEEP_LAT_LSB     = 15;
    localparam int SHALLOW_LAT_LSB  = 12;
    localparam int ASPM_LSB         = 10;
    localparam int LANE_LSB         = 4;
    localparam int RATE_LSB         = 0;

    // fixed and reset values
    localparam logic [7:0] PORT_IDX_VAL     = 8'h00;
    localparam logic [2:0] RSVD_VAL         = 3'h0;
    localparam logic       ACT_REP_VAL      = 1'b0;
    localparam logic       LOSS_REP_VAL     = 1'b0;
    localparam logic       REFCLK_VAL       = 1'b0;
    localparam logic [2:0] DEEP_LAT_RST     = 3'h2;
    localparam logic [2:0] SHALLOW_LAT_RST  = 3'h3;
    localparam logic [1:0] ASPM_VAL         = 2'h3;
    localparam logic [5:0] LANE_VAL         = 6'h01;
    localparam logic [3:0] RATE_VAL         = 4'h1;
    localparam logic [31:0] LINK_CAP_RST    = 32'h00013C11;

    // load staging register layout
    localparam int LOAD_DEEP_LSB    = 0;
    localparam int LOAD_SHALLOW_LSB = 4;
    localparam int LOAD_DEEP_EN     = 8;
    localparam int LOAD_SHALLOW_EN  = 9;

    // shallow latency code bounds, in ns (upper bound, exclusive)
    localparam int SHALLOW_BASE_NS  = 64;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hw/latency_decode.sv]
`timescale 1ns/1ps
module latency_decode
    import link_cap_pkg::*;
(
    // code in
    input  wire logic [2:0]  code,
    // range out, ns; max_ns zero means open ended
    output logic      [15:0] min_ns,
    output logic      [15:0] max_ns
);
    // from code 2 to code 6 each code doubles both bounds of the previous range; top code open from 4096 ns
    always_comb begin
        if (code == 3'h0) begin
            min_ns = 16'h0000;
            max_ns = 16'(SHALLOW_BASE_NS);
        end else if (code == 3'h7) begin
            min_ns = 16'(SHALLOW_BASE_NS << 6);
            max_ns = 16'h0000;
        end else begin
            min_ns = 16'(SHALLOW_BASE_NS << (code - 3'h1));
            max_ns = 16'(SHALLOW_BASE_NS << code);
        end
    end
endmodule // latency_decode

// [hw/load_port.sv]
`timescale 1ns/1ps
module load_port
    import link_cap_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // eeprom load strobe and word
    input  wire logic        load_valid,
    input  wire logic [31:0] load_word,
    // decoded update
    output logic             deep_we,
    output logic [2:0]       deep_val,
    output logic             shallow_we,
    output logic [2:0]       shallow_val,
    output logic [31:0]      last_word
);
    typedef struct packed {
        logic [31:0] word;
    } state_t;
    state_t s_q, s_d;

    // enables carried in the load word so one field can load alone
    assign deep_we     = load_valid && load_word[LOAD_DEEP_EN];
    assign shallow_we  = load_valid && load_word[LOAD_SHALLOW_EN];
    assign deep_val    = load_word[LOAD_DEEP_LSB +: 3];
    assign shallow_val = load_word[LOAD_SHALLOW_LSB +: 3];
    assign last_word   = s_q.word;

    always_comb begin
        s_d = s_q;
        if (load_valid) begin
            s_d.word = load_word;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // load_port

// [hw/link_capability_register.sv]
`timescale 1ns/1ps
module link_capability_register
    import link_cap_pkg::*;
(
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write address
    input  wire logic [link_cap_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read address
    input  wire logic [link_cap_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // eeprom load path
    input  wire logic                      load_valid,
    input  wire logic [31:0]               load_word,
    // decoded shallow latency range
    output logic [15:0]                    shallow_min_ns,
    output logic [15:0]                    shallow_max_ns
);
    typedef struct packed {
        logic        aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic        w_have;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [2:0]  deep_lat;
        logic [2:0]  shallow_lat;
        logic [3:0]  load_count;
    } state_t;

    state_t s_q, s_d;

    logic        deep_we;
    logic [2:0]  deep_val;
    logic        shallow_we;
    logic [2:0]  shallow_val;
    logic [31:0] last_word;
    logic [31:0] cap_word;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == LINK_CAP_OFFSET) || (a == LOAD_DATA_OFFSET)
              || (a == LOAD_STATUS_OFFSET);
    endfunction

    load_port i_load_port (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .load_valid  (load_valid),
        .load_word   (load_word),
        .deep_we     (deep_we),
        .deep_val    (deep_val),
        .shallow_we  (shallow_we),
        .shallow_val (shallow_val),
        .last_word   (last_word)
    );

    latency_decode i_latency_decode (
        .code   (s_q.shallow_lat),
        .min_ns (shallow_min_ns),
        .max_ns (shallow_max_ns)
    );

    // fixed fields are constants so no path can ever disturb them
    always_comb begin
        cap_word = '0;
        cap_word[PORT_IDX_LSB +: 8]    = PORT_IDX_VAL;
        cap_word[RSVD_LSB +: 3]        = RSVD_VAL;
        cap_word[ACT_REP_BIT]          = ACT_REP_VAL;
        cap_word[LOSS_REP_BIT]         = LOSS_REP_VAL;
        cap_word[REFCLK_BIT]           = REFCLK_VAL;
        cap_word[DEEP_LAT_LSB +: 3]    = s_q.deep_lat;
        cap_word[SHALLOW_LAT_LSB +: 3] = s_q.shallow_lat;
        cap_word[ASPM_LSB +: 2]        = ASPM_VAL;
        cap_word[LANE_LSB +: 6]        = LANE_VAL;
        cap_word[RATE_LSB +: 4]        = RATE_VAL;
    end

    assign s_axi_awready = !s_q.aw_have && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_have && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rresp   = s_q.rresp;
    assign s_axi_rdata   = s_q.rdata;

    always_comb begin
        s_d = s_q;
        // write channel: data is accepted and dropped, all fields read-only
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_have = 1'b1;
        end
        if (s_d.aw_have && s_d.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = mapped(s_d.aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                LINK_CAP_OFFSET:    s_d.rdata = cap_word;
                LOAD_DATA_OFFSET:   s_d.rdata = last_word;
                LOAD_STATUS_OFFSET: s_d.rdata = {28'h0000000, s_q.load_count};
                default:            s_d.rdata = 32'h00000000;
            endcase
        end
        // latencies move only on the eeprom load path
        if (deep_we) begin
            s_d.deep_lat = deep_val;
        end
        if (shallow_we) begin
            s_d.shallow_lat = shallow_val;
        end
        if (load_valid) begin
            s_d.load_count = s_q.load_count + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q             <= '0;
            s_q.deep_lat    <= DEEP_LAT_RST;
            s_q.shallow_lat <= SHALLOW_LAT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // fixed fields on every read of the capability word
    a_fixed_fields: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == LINK_CAP_OFFSET)
        |=> (s_axi_rvalid && s_axi_rdata[31:24] == 8'h00))
        else $error("port index field wrong");

    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == LINK_CAP_OFFSET)
        |=> (s_axi_rresp == RESP_OKAY && s_axi_rdata[23:21] == 3'h0))
        else $error("reserved bits not zero");

    a_flags_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == LINK_CAP_OFFSET)
        |=> (s_axi_rdata[20:18] == 3'h0))
        else $error("capability flags not zero");

    a_latency_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == LINK_CAP_OFFSET)
        |=> (s_axi_rdata[17:12] == $past({s_q.deep_lat, s_q.shallow_lat})))
        else $error("latency fields not read back");

    a_reset_value: assert property (@(posedge aclk)
        $past(!aresetn) |-> cap_word == LINK_CAP_RST)
        else $error("capability word not at reset value");

    a_shallow_load: assert property (@(posedge aclk) disable iff (!aresetn)
        shallow_we |=> s_q.shallow_lat == $past(shallow_val))
        else $error("shallow latency not loaded");

    a_deep_load: assert property (@(posedge aclk) disable iff (!aresetn)
        deep_we |=> s_q.deep_lat == $past(deep_val))
        else $error("deep latency not loaded");

    a_write_inert: assert property (@(posedge aclk) disable iff (!aresetn)
        !load_valid |=> $stable(cap_word))
        else $error("capability changed without load");

    a_aspm_lane_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == LINK_CAP_OFFSET)
        |=> (s_axi_rdata[11:0] == 12'hC11))
        else $error("aspm, lane or rate field wrong");

    // every shallow code against its range
    a_decode_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.shallow_lat == 3'h0 |-> shallow_min_ns == 16'h0000 && shallow_max_ns == 16'h0040)
        else $error("latency decode wrong for code 0");

    a_decode_one: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.shallow_lat == 3'h1 |-> shallow_min_ns == 16'h0040 && shallow_max_ns == 16'h0080)
        else $error("latency decode wrong for code 1");

    a_decode_two: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.shallow_lat == 3'h2 |-> shallow_min_ns == 16'h0080 && shallow_max_ns == 16'h0100)
        else $error("latency decode wrong for code 2");

    a_decode_low: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.shallow_lat == 3'h3 |-> shallow_min_ns == 16'h0100 && shallow_max_ns == 16'h0200)
        else $error("latency decode wrong");

    a_decode_four: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.shallow_lat == 3'h4 |-> shallow_min_ns == 16'h0200 && shallow_max_ns == 16'h0400)
        else $error("latency decode wrong for code 4");

    a_decode_five: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.shallow_lat == 3'h5 |-> shallow_min_ns == 16'h0400 && shallow_max_ns == 16'h0800)
        else $error("latency decode wrong for code 5");

    a_decode_six: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.shallow_lat == 3'h6 |-> shallow_min_ns == 16'h0800 && shallow_max_ns == 16'h1000)
        else $error("latency decode wrong for code 6");

    a_decode_top: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.shallow_lat == 3'h7 |-> shallow_min_ns == 16'h1000 && shallow_max_ns == 16'h0000)
        else $error("latency decode wrong for code 7");

    // bus answers
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");

    a_write_okay: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && mapped(s_axi_awaddr)
        |=> s_axi_bresp == RESP_OKAY)
        else $error("mapped write not answered okay");

    a_write_slverr: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !mapped(s_axi_awaddr)
        |=> s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    a_bvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired");

    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");

    a_rvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not retired");

    a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr)
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");

    a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == LOAD_STATUS_OFFSET
        |=> s_axi_rdata[31:4] == 28'h0000000)
        else $error("load status upper bits not zero");

    a_reset_idle: assert property (@(posedge aclk)
        $past(!aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready
        && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus not idle after reset");

    // load path
    a_last_word: assert property (@(posedge aclk) disable iff (!aresetn)
        load_valid |=> last_word == $past(load_word))
        else $error("last load word not kept");

    a_load_count: assert property (@(posedge aclk) disable iff (!aresetn)
        load_valid |=> s_q.load_count == $past(s_q.load_count) + 4'h1)
        else $error("load count not advanced");

    // a bus write in the same cycle must not disturb the latencies
    a_shallow_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !shallow_we |=> $stable(s_q.shallow_lat))
        else $error("shallow latency moved without load");

    a_deep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !deep_we |=> $stable(s_q.deep_lat))
        else $error("deep latency moved without load");
endmodule // link_capability_register

// [testbench/link_capability_register_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module link_capability_register_bench;
    import link_cap_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, load_valid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, load_word, exp_q, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [15:0] shallow_min_ns, shallow_max_ns;
    logic [3:0]  n_loads;
    int          num_errors = 0;
    int          cmp_count = 0;

    link_capability_register i_link_capability_register (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .load_valid, .load_word, .shallow_min_ns, .shallow_max_ns
    );

    always #2.5 aclk = ~aclk;

    // shallow code bounds in ns, min then max; max zero is open ended
    function automatic logic [31:0] exp_range(input logic [2:0] c);
        case (c)
            3'h0:    return {16'h0000, 16'h0040};
            3'h1:    return {16'h0040, 16'h0080};
            3'h2:    return {16'h0080, 16'h0100};
            3'h3:    return {16'h0100, 16'h0200};
            3'h4:    return {16'h0200, 16'h0400};
            3'h5:    return {16'h0400, 16'h0800};
            3'h6:    return {16'h0800, 16'h1000};
            default: return {16'h1000, 16'h0000};
        endcase
    endfunction

    // ready sampled at the falling edge, settled and equal to its value at the next rise
    task automatic axi_write(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] rs);
        logic aw_ok, w_ok, b_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= wd;
        s_axi_wstrb <= 4'($urandom);
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge aclk);
            if (s_axi_awready === 1'b1) aw_ok = 1'b1;
            if (s_axi_wready === 1'b1) w_ok = 1'b1;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        while (!b_ok) begin
            @(negedge aclk);
            b_ok = (s_axi_bvalid === 1'b1);
            rs = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rs);
        logic ok;
        ok = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!ok) begin
            @(negedge aclk);
            ok = (s_axi_arready === 1'b1);
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        ok = 1'b0;
        while (!ok) begin
            @(negedge aclk);
            ok = (s_axi_rvalid === 1'b1);
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
    endtask

    task automatic do_load(input logic [31:0] w);
        @(posedge aclk);
        load_valid <= 1'b1;
        load_word <= w;
        @(posedge aclk);
        load_valid <= 1'b0;
        if (w[8]) exp_q[17:15] = w[2:0];
        if (w[9]) exp_q[14:12] = w[6:4];
        n_loads = n_loads + 4'h1;
    endtask

    task automatic check_all();
        logic [31:0] rng;
        axi_read(LINK_CAP_OFFSET, d, r);
        rng = exp_range(exp_q[14:12]);
        `CHK("resp", RESP_OKAY, r)
        `CHK("port_idx", 8'h00, d[31:24])
        `CHK("rsvd", 3'h0, d[23:21])
        `CHK("act_rep", 1'b0, d[20])
        `CHK("loss_rep", 1'b0, d[19])
        `CHK("refclk", 1'b0, d[18])
        `CHK("latencies", exp_q[17:12], d[17:12])
        `CHK("aspm", 2'b11, d[11:10])
        `CHK("lanes", 6'h01, d[9:4])
        `CHK("rate", 4'h1, d[3:0])
        `CHK("min_ns", rng[31:16], shallow_min_ns)
        `CHK("max_ns", rng[15:0], shallow_max_ns)
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // whole run is a few hundred cycles; this is 20000 cycles, well over ten times that
    initial begin
        #100000;
        num_errors++;
        close_out();
    end

    initial begin
        logic [31:0] w;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 28'h0000000;
        {s_axi_wdata, load_word, load_valid} = 65'h0;
        exp_q = 32'h00013C11;
        n_loads = 4'h0;
        void'($urandom(32'hCD10));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check_all();
        // ordinary writes must leave every field alone
        for (int i = 0; i < 4; i++) begin
            axi_write(LINK_CAP_OFFSET, (i == 0) ? 32'hFFFFFFFF : $urandom, r);
            `CHK("wr_resp", RESP_OKAY, r)
            check_all();
        end
        // every shallow code once, then random words with random enables
        for (int i = 0; i < 16; i++) begin
            w = $urandom;
            if (i < 8) begin
                w[6:4] = 3'(i);
                w[9] = 1'b1;
            end
            do_load(w);
            check_all();
            axi_write(LINK_CAP_OFFSET, ~w, r);
            check_all();
        end
        axi_read(12'h100, d, r);
        `CHK("unmapped_rresp", RESP_SLVERR, r)
        `CHK("unmapped_rdata", 32'h00000000, d)
        axi_write(12'h100, $urandom, r);
        `CHK("unmapped_bresp", RESP_SLVERR, r)
        // a second reset drops loaded latencies back to their defaults
        do_load(32'h0000037F);
        check_all();
        axi_read(LOAD_DATA_OFFSET, d, r);
        `CHK("last_word", 32'h0000037F, d)
        axi_read(LOAD_STATUS_OFFSET, d, r);
        `CHK("status_resp", RESP_OKAY, r)
        `CHK("load_count", n_loads, d[3:0])
        `CHK("count_hi", 28'h0000000, d[31:4])
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        exp_q = 32'h00013C11;
        check_all();
        axi_read(LOAD_STATUS_OFFSET, d, r);
        `CHK("count_rst", 32'h00000000, d)
        axi_read(LOAD_DATA_OFFSET, d, r);
        `CHK("word_rst", 32'h00000000, d)
        close_out();
    end
endmodule // link_capability_register_bench
